// File: hw/nerc_top.sv
// Purpose: Configuration stamp and error-reaction register bank with state keeping
// Assumes: Error pulses come from logic on clk_in; one-cycle strobes
// Notes:   Read data stand only in the cycle after the read strobe
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module nerc_top #(
  parameter logic [31:0] SERIAL_WORD = nerc_pkg::SERIAL_RST // Arbitrary neutral value
) (
  input  wire logic        clk_in,        // 250 MHz clock
  input  wire logic        rst_n_in,      // Async reset, active low
  input  wire logic [7:0]  addr_in,       // Register byte address
  input  wire logic [31:0] wr_data_in,    // Write data
  input  wire logic        wr_en_in,      // Write strobe
  input  wire logic        rd_en_in,      // Read strobe
  output logic      [31:0] rd_data_out,   // Read data, cycle after strobe
  input  wire logic        comm_err_in,   // Communication error pulse
  input  wire logic        int_err_in,    // Other internal error pulse
  output logic      [1:0]  nmt_state_out, // Current state code
  output logic             sel_reject_out // Last selector write refused
);

  // Reset release through two flops; assertion is immediate
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Selector codes beyond stopped have no meaning, so they are screened
  function automatic logic sel_valid(input logic [31:0] d);
    sel_valid = (d[31:8] == 24'h000000) && (d[7:0] <= nerc_pkg::REACT_STOP);
  endfunction

  logic [31:0]         day_r;
  logic [31:0]         ms_r;
  logic [7:0]          comm_sel_r;
  logic [7:0]          int_sel_r;
  logic                reject_r;
  nerc_pkg::nerc_nmt_t state_r;
  nerc_pkg::nerc_nmt_t state_nxt;
  logic [31:0]         rdata_r;
  logic [31:0]         rdata_nxt;

  wire logic wr_day  = wr_en_in && (addr_in == nerc_pkg::OFS_DAY);
  wire logic wr_ms   = wr_en_in && (addr_in == nerc_pkg::OFS_MS);
  wire logic wr_comm = wr_en_in && (addr_in == nerc_pkg::OFS_COMM_REACT);
  wire logic wr_int  = wr_en_in && (addr_in == nerc_pkg::OFS_INT_REACT);
  wire logic wr_nmt  = wr_en_in && (addr_in == nerc_pkg::OFS_NMT);

  // Date stamp: stored as written, no interpretation
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      day_r <= nerc_pkg::DAY_RST;
    end else if (wr_day) begin
      day_r <= wr_data_in; // RULE_03
    end
  end

  // Time stamp: stored as written
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ms_r <= nerc_pkg::MS_RST;
    end else if (wr_ms) begin
      ms_r <= wr_data_in; // RULE_04
    end
  end

  // Selectors take only legal codes; others leave the old value
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      comm_sel_r <= nerc_pkg::COMM_REACT_RST;
    end else if (wr_comm && sel_valid(wr_data_in)) begin
      comm_sel_r <= wr_data_in[7:0]; // RULE_07
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      int_sel_r <= nerc_pkg::INT_REACT_RST;
    end else if (wr_int && sel_valid(wr_data_in)) begin
      int_sel_r <= wr_data_in[7:0]; // RULE_07
    end
  end

  // Refusal flag follows the most recent selector write
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reject_r <= 1'b0;
    end else if (wr_comm || wr_int) begin
      reject_r <= !sel_valid(wr_data_in); // RULE_07
    end
  end

  // One decoder per error source
  logic       err_vec   [2];
  logic [7:0] sel_vec   [2];
  logic       preop_vec [2];
  logic       stop_vec  [2];
  assign err_vec[0] = comm_err_in;
  assign sel_vec[0] = comm_sel_r;
  assign err_vec[1] = int_err_in;
  assign sel_vec[1] = int_sel_r;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_react
      nerc_reaction u_react (
        .err_in       (err_vec[gi]),
        .state_in     (state_r),
        .sel_in       (sel_vec[gi]),
        .to_preop_out (preop_vec[gi]),
        .to_stop_out  (stop_vec[gi])
      );
    end
  endgenerate

  // Stopped outranks pre-op, and any error stop or pre-op request outranks a software state write
  always_comb begin
    state_nxt = state_r;
    if (stop_vec[0] || stop_vec[1]) begin
      state_nxt = nerc_pkg::NERC_STOP; // RULE_01 RULE_02
    end else if (preop_vec[0] || preop_vec[1]) begin
      state_nxt = nerc_pkg::NERC_PREOP; // RULE_01 RULE_02
    end else if (wr_nmt) begin
      unique case (wr_data_in[1:0])
        2'h0: state_nxt = nerc_pkg::NERC_PREOP;
        2'h1: state_nxt = nerc_pkg::NERC_OPER;
        2'h3: state_nxt = nerc_pkg::NERC_STOP;
        default: state_nxt = state_r; // Unused code ignored
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= nerc_pkg::NMT_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (rd_en_in) begin
      unique case (addr_in)
        nerc_pkg::OFS_SERIAL:     rdata_nxt = SERIAL_WORD;
        nerc_pkg::OFS_STAMP_CNT:  rdata_nxt = {24'h000000, nerc_pkg::STAMP_CNT_RST};
        nerc_pkg::OFS_DAY:        rdata_nxt = day_r; // RULE_03
        nerc_pkg::OFS_MS:         rdata_nxt = ms_r; // RULE_04
        nerc_pkg::OFS_ERR_CNT:    rdata_nxt = {24'h000000, nerc_pkg::ERR_CNT_RST};
        nerc_pkg::OFS_COMM_REACT: rdata_nxt = {24'h000000, comm_sel_r};
        nerc_pkg::OFS_INT_REACT:  rdata_nxt = {24'h000000, int_sel_r};
        nerc_pkg::OFS_NMT: begin
          rdata_nxt[nerc_pkg::NMT_STATE_LSB +: 2] = state_r;
          rdata_nxt[nerc_pkg::REJECT_BIT]         = reject_r;
        end
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Data drop back to zero after their one cycle
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rd_data_out    = rdata_r;
  assign nmt_state_out  = state_r;
  assign sel_reject_out = reject_r;

  // Checks
  sequence comm_stop_s;
    comm_err_in && (comm_sel_r == nerc_pkg::REACT_STOP);
  endsequence

  sequence comm_preop_s;
    comm_err_in && (comm_sel_r == nerc_pkg::REACT_PREOP) && (state_r == nerc_pkg::NERC_OPER)
      && !(int_err_in && (int_sel_r == nerc_pkg::REACT_STOP));
  endsequence

  sequence int_hold_s;
    int_err_in && (int_sel_r == nerc_pkg::REACT_HOLD) && !comm_err_in && !wr_nmt;
  endsequence

  sequence day_wr_rd_s;
    wr_day ##1 (rd_en_in && (addr_in == nerc_pkg::OFS_DAY));
  endsequence

  sequence ms_wr_rd_s;
    wr_ms ##1 (rd_en_in && (addr_in == nerc_pkg::OFS_MS));
  endsequence

  a_comm_err_stop: assert property (@(posedge clk_in) disable iff (!rst_n_r) // RULE_01
    comm_stop_s |=> (state_r == nerc_pkg::NERC_STOP) && (nmt_state_out == 2'h3))
    else $error("comm error with stop code did not stop");

  a_comm_err_preop: assert property (@(posedge clk_in) disable iff (!rst_n_r) // RULE_01
    comm_preop_s |=> (state_r == nerc_pkg::NERC_PREOP))
    else $error("comm error did not leave operational");

  a_int_err_hold: assert property (@(posedge clk_in) disable iff (!rst_n_r) // RULE_02
    int_hold_s |=> $stable(state_r))
    else $error("internal error with hold code changed state");

  a_day_readback: assert property (@(posedge clk_in) disable iff (!rst_n_r) // RULE_03
    day_wr_rd_s |=> (rd_data_out == $past(wr_data_in, 2)))
    else $error("day stamp not read back unchanged");

  a_ms_readback: assert property (@(posedge clk_in) disable iff (!rst_n_r) // RULE_04
    ms_wr_rd_s |=> (rd_data_out == $past(wr_data_in, 2)))
    else $error("time stamp not read back unchanged");

  a_sel_reject_keep: assert property (@(posedge clk_in) disable iff (!rst_n_r) // RULE_07
    (wr_comm && !sel_valid(wr_data_in)) |=> $stable(comm_sel_r) && sel_reject_out)
    else $error("illegal selector code was stored");

endmodule
`default_nettype wire

// File: hw/nerc_pkg.sv
// Purpose: Constants and types for the error-reaction and configuration-stamp register bank
// Assumes: 32-bit plain register port, word-aligned byte offsets
// Notes:   Shared by the top and the reaction decoder
//
// Functional notes
// RULE_01: Comm error applies comm selector to state
// RULE_02: Other errors apply internal selector, same coding
// RULE_03: Day count stored and read back unchanged
// RULE_04: Millisecond count stored and read back unchanged
// RULE_05: Tool writes date and time before saving
// RULE_06: Master reads stamp after reset to verify
// RULE_07: Selector codes above 02 rejected, value kept
package nerc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_SERIAL     = 8'h00;
  localparam logic [7:0] OFS_STAMP_CNT  = 8'h04;
  localparam logic [7:0] OFS_DAY        = 8'h08;
  localparam logic [7:0] OFS_MS         = 8'h0C;
  localparam logic [7:0] OFS_ERR_CNT    = 8'h10;
  localparam logic [7:0] OFS_COMM_REACT = 8'h14;
  localparam logic [7:0] OFS_INT_REACT  = 8'h18;
  localparam logic [7:0] OFS_NMT        = 8'h1C;

  // Values after reset
  localparam logic [7:0]  STAMP_CNT_RST  = 8'h02;
  localparam logic [7:0]  ERR_CNT_RST    = 8'h02;
  localparam logic [31:0] DAY_RST        = 32'h00000000;
  localparam logic [31:0] MS_RST         = 32'h00000000;
  localparam logic [7:0]  COMM_REACT_RST = 8'h00;
  localparam logic [7:0]  INT_REACT_RST  = 8'h01;
  localparam logic [31:0] SERIAL_RST     = 32'h00000000;

  // Selector coding
  localparam logic [7:0] REACT_PREOP = 8'h00;
  localparam logic [7:0] REACT_HOLD  = 8'h01;
  localparam logic [7:0] REACT_STOP  = 8'h02;

  // Status field positions in the state register
  localparam int NMT_STATE_LSB = 0;
  localparam int REJECT_BIT    = 8;

  // Network-management states, Gray along pre-op, operational, stopped
  typedef enum logic [1:0] {
    NERC_PREOP = 2'b00,
    NERC_OPER  = 2'b01,
    NERC_STOP  = 2'b11
  } nerc_nmt_t;

  localparam nerc_nmt_t NMT_RST = NERC_PREOP;

endpackage

// File: hw/nerc_reaction.sv
// Purpose: Decodes one error selector into a state-change request
// Assumes: Selector already screened to codes 00..02
// Notes:   Purely combinational; one instance per error source
`timescale 1ns/1ps
`default_nettype none
module nerc_reaction (
  input  wire logic              err_in,       // Error event this cycle
  input  wire nerc_pkg::nerc_nmt_t state_in,   // Current state
  input  wire logic [7:0]        sel_in,       // Reaction selector
  output logic                   to_preop_out, // Request pre-operational
  output logic                   to_stop_out   // Request stopped
);

  // Code 00 acts only from operational; code 01 asks for nothing
  always_comb begin
    to_preop_out = err_in && (sel_in == nerc_pkg::REACT_PREOP)
                   && (state_in == nerc_pkg::NERC_OPER); // RULE_01 RULE_02
    to_stop_out  = err_in && (sel_in == nerc_pkg::REACT_STOP); // RULE_01 RULE_02
  end

endmodule
`default_nettype wire

// File: tb/nerc_master_model.sv
// Purpose: Network master model driving the register port of the bank
// Assumes: One-cycle strobes, read data one cycle after the strobe
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module nerc_master_model (
  input  wire logic        clk_in,      // Bench clock
  input  wire logic [31:0] rd_data_in,  // Read data from the bank
  output logic      [7:0]  addr_out,    // Register address
  output logic      [31:0] wr_data_out, // Write data
  output logic             wr_en_out,   // Write strobe
  output logic             rd_en_out    // Read strobe
);
  // Idle bus from time zero
  initial begin
    addr_out    = 8'h00;
    wr_data_out = 32'h00000000;
    wr_en_out   = 1'b0;
    rd_en_out   = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out    <= a;
    wr_data_out <= d;
    wr_en_out   <= 1'b1;
    @(posedge clk_in);
    wr_en_out   <= 1'b0;
    addr_out    <= ~a; // No stale address after release
    wr_data_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out  <= ~a;
    @(posedge clk_in);
    d = rd_data_in; // Data stand only in this cycle
  endtask
  // Write, then a read of the same place on the very next strobe
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    addr_out    <= a;
    wr_data_out <= d;
    wr_en_out   <= 1'b1;
    @(posedge clk_in);
    wr_en_out   <= 1'b0; // No gap: the read strobe follows at once
    rd_en_out   <= 1'b1;
    @(posedge clk_in);
    rd_en_out   <= 1'b0;
    addr_out    <= ~a;
    wr_data_out <= ~d;
    @(posedge clk_in);
    q = rd_data_in;
  endtask
  // Date first, then time, so a later save carries a matching stamp
  task automatic set_stamp(input logic [31:0] day, input logic [31:0] ms);
    wr(nerc_pkg::OFS_DAY, day);
    wr(nerc_pkg::OFS_MS, ms);
  endtask
  // After a device reset, compare the stamp and reconfigure on mismatch
  task automatic verify_stamp(input logic [31:0] day, input logic [31:0] ms,
                              output logic redo);
    logic [31:0] d;
    logic [31:0] m;
    rd(nerc_pkg::OFS_DAY, d);
    rd(nerc_pkg::OFS_MS, m);
    redo = (d !== day) || (m !== ms);
    if (redo) set_stamp(day, ms);
  endtask
endmodule
`default_nettype wire

// File: tb/nmt_error_reaction_cfg_verify_tb.sv
// Purpose: Self-checking bench for the stamp and error-reaction bank
// Assumes: 250 MHz clock, reset held 20 cycles
// Notes:   Stamp is volatile here, so a reset forces reconfiguration
`timescale 1ns/1ps
`default_nettype none
module nmt_error_reaction_cfg_verify_tb;
  localparam logic [31:0] SER = 32'h5A5A1234; // Arbitrary value
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        comm_err_in = 1'b0;
  logic        int_err_in = 1'b0;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr_en;
  logic        rd_en;
  logic [1:0]  nmt_state_out;
  logic        sel_reject_out;
  int          err_count = 0;
  int          checked = 0;
  int          cycles = 0;
  // Clock of 4 ns period
  always #2 clk_in = ~clk_in;
  nerc_top #(.SERIAL_WORD(SER)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wr_data_in(wdata),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
    .comm_err_in(comm_err_in), .int_err_in(int_err_in),
    .nmt_state_out(nmt_state_out), .sel_reject_out(sel_reject_out));
  nerc_master_model mst_u (
    .clk_in(clk_in), .rd_data_in(rdata), .addr_out(addr), .wr_data_out(wdata),
    .wr_en_out(wr_en), .rd_en_out(rd_en));
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic [31:0] v;
    mst_u.rd(a, v);
    chk(v, exp, m);
  endtask
  // Reset values, read-only places and an unmapped address
  task automatic reset_values;
    logic [7:0]  ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [31:0] exv [9] = '{SER, 32'h2, 32'h0, 32'h0, 32'h2, 32'h0, 32'h1, 32'h0, 32'h0};
    mst_u.wr(8'h04, 32'hFFFFFFFF);
    mst_u.wr(8'h20, 32'hFFFFFFFF);
    for (int i = 0; i < 9; i++) rdchk(ofs[i], exv[i], "reset map");
  endtask
  // Stamp round trip, then a device reset and the master's check
  task automatic stamp_roundtrip;
    logic redo;
    logic [31:0] v;
    mst_u.set_stamp(32'hFFFFFFFF, 32'h05265BFF);
    rdchk(nerc_pkg::OFS_DAY, 32'hFFFFFFFF, "day");
    rdchk(nerc_pkg::OFS_MS, 32'h05265BFF, "ms");
    mst_u.wr_rd(nerc_pkg::OFS_DAY, 32'h00003A2F, v);
    chk(v, 32'h00003A2F, "day back to back");
    mst_u.wr_rd(nerc_pkg::OFS_MS, 32'h00000001, v);
    chk(v, 32'h00000001, "ms back to back");
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    mst_u.verify_stamp(32'h00003A2F, 32'h00000000, redo);
    chk({31'h0, redo}, 32'h1, "stamp lost");
    mst_u.verify_stamp(32'h00003A2F, 32'h00000000, redo);
    chk({31'h0, redo}, 32'h0, "stamp kept");
  endtask
  // Illegal selector codes are refused and flagged
  task automatic selector_screen;
    mst_u.wr(nerc_pkg::OFS_COMM_REACT, 32'h03);
    @(posedge clk_in); // Flag is launched by the strobe edge, look one edge later
    chk({31'h0, sel_reject_out}, 32'h1, "reject flag");
    rdchk(nerc_pkg::OFS_COMM_REACT, 32'h0, "comm kept");
    mst_u.wr(nerc_pkg::OFS_INT_REACT, 32'h102);
    rdchk(nerc_pkg::OFS_INT_REACT, 32'h1, "int kept");
    mst_u.wr(nerc_pkg::OFS_INT_REACT, 32'h02);
    rdchk(nerc_pkg::OFS_NMT, 32'h0, "flag cleared");
    @(posedge clk_in); // Read data stand one cycle only
    chk(rdata, 32'h0, "read data dropped");
    mst_u.wr(nerc_pkg::OFS_NMT, 32'h1);
    mst_u.wr(nerc_pkg::OFS_NMT, 32'h2);
    rdchk(nerc_pkg::OFS_NMT, 32'h1, "state code 2 ignored");
  endtask
  // Every source, code and start state
  task automatic reaction_table;
    logic [1:0] st [3] = '{2'b00, 2'b01, 2'b11};
    logic [1:0] exp;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 3; c++)
        for (int k = 0; k < 3; k++) begin
          mst_u.wr(s ? nerc_pkg::OFS_INT_REACT : nerc_pkg::OFS_COMM_REACT, 32'(c));
          mst_u.wr(nerc_pkg::OFS_NMT, {30'h0, st[k]});
          exp = (c == 2) ? 2'b11 : (c == 0 && st[k] == 2'b01) ? 2'b00 : st[k];
          @(posedge clk_in);
          comm_err_in <= (s == 0);
          int_err_in  <= (s == 1);
          @(posedge clk_in);
          comm_err_in <= 1'b0;
          int_err_in  <= 1'b0;
          @(posedge clk_in);
          chk({30'h0, nmt_state_out}, {30'h0, exp}, "reaction");
        end
  endtask
  // Hang guard, well above the expected run of under 1000 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done;
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    reset_values;
    stamp_roundtrip;
    selector_screen;
    reaction_table;
    test_done;
  end
endmodule
`default_nettype wire
